// ==== design/acwd_pkg.sv ====
// constants and types shared by the converter control and window detector
package acwd_pkg;

	// ----------------------------------------------------------------
	// register addresses on the special function register bus
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RES_LO = 8'hbe;
	localparam logic [7:0] ADDR_RES_HI = 8'hbf;
	localparam logic [7:0] ADDR_GT_LO = 8'hc4;
	localparam logic [7:0] ADDR_GT_HI = 8'hc5;
	localparam logic [7:0] ADDR_LT_LO = 8'hc6;
	localparam logic [7:0] ADDR_LT_HI = 8'hc7;
	localparam logic [7:0] ADDR_CTL = 8'he8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_RES_LO = 8'h00;
	localparam logic [7:0] RST_RES_HI = 8'h00;
	localparam logic [7:0] RST_GT_LO = 8'hff;
	localparam logic [7:0] RST_GT_HI = 8'hff;
	localparam logic [7:0] RST_LT_LO = 8'h00;
	localparam logic [7:0] RST_LT_HI = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ----------------------------------------------------------------
	// converter_control bit positions
	// ----------------------------------------------------------------
	localparam int BIT_ENABLE = 7;
	localparam int BIT_TRACK_MODE = 6;
	localparam int BIT_DONE = 5;
	localparam int BIT_BUSY = 4;
	localparam int BIT_MODE_HI = 3;
	localparam int BIT_MODE_LO = 2;
	localparam int BIT_WIN = 1;
	localparam int BIT_LJUST = 0;

	// ----------------------------------------------------------------
	// start modes, result layout and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] START_SW = 2'h0;
	localparam logic [1:0] START_TMR3 = 2'h1;
	localparam logic [1:0] START_PIN = 2'h2;
	localparam logic [1:0] START_TMR2 = 2'h3;

	localparam int RES_BITS = 12;
	localparam int WORD_BITS = 16;
	localparam logic [3:0] PAD_ZERO = 4'h0;
	localparam int TRACK_SAR_CLKS = 3;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_IDLE,
		ST_TRACK,
		ST_CONV
	} acwd_state_t;

endpackage

// ==== design/acwd_window.sv ====
// result formatter and programmable window comparator
`timescale 1ns/1ps
module acwd_window
	import acwd_pkg::*;
(
	// raw conversion result
	input logic [acwd_pkg::RES_BITS-1:0] data_i,
	input logic left_justify_i,
	input logic diff_i,
	// limit words
	input logic [acwd_pkg::WORD_BITS-1:0] lt_word_i,
	input logic [acwd_pkg::WORD_BITS-1:0] gt_word_i,
	// formatted word and compare outcome
	output logic [acwd_pkg::WORD_BITS-1:0] word_o,
	output logic hit_o
);

	logic [WORD_BITS:0] word_x;
	logic [WORD_BITS:0] lt_x;
	logic [WORD_BITS:0] gt_x;
	logic below_lt;
	logic above_gt;

	// ----------------------------------------------------------------
	// layout
	// ----------------------------------------------------------------
	always_comb
	begin
		if (left_justify_i)
		begin
			word_o = {data_i, PAD_ZERO};
		end
		else if (diff_i)
		begin
			word_o = {{(WORD_BITS-RES_BITS){data_i[RES_BITS-1]}}, data_i};
		end
		else
		begin
			word_o = {PAD_ZERO, data_i};
		end
	end

	// ----------------------------------------------------------------
	// compare
	// ----------------------------------------------------------------
	// one extra bit: sign copy for differential, zero otherwise, so a single
	// signed compare serves both readings
	always_comb
	begin
		word_x = {diff_i & word_o[WORD_BITS-1], word_o};
		lt_x = {diff_i & lt_word_i[WORD_BITS-1], lt_word_i};
		gt_x = {diff_i & gt_word_i[WORD_BITS-1], gt_word_i};
		below_lt = $signed(word_x) < $signed(lt_x);
		above_gt = $signed(word_x) > $signed(gt_x);
		if ($signed(lt_x) > $signed(gt_x))
		begin
			hit_o = below_lt & above_gt;
		end
		else
		begin
			hit_o = below_lt | above_gt;
		end
	end

endmodule // acwd_window

// ==== design/acwd_top.sv ====
// converter control: start selection, tracking, busy/done flags, result and window
`timescale 1ns/1ps
module acwd_top
	import acwd_pkg::*;
#(
	parameter int SAR_DIV = 2,
	parameter int CONV_SAR_CLKS = 16
)
(
	// clock and reset
	input logic clk_sys_i,
	input logic nrst_i,
	// special function register bus
	input logic [7:0] sfr_addr_i,
	input logic sfr_wr_i,
	input logic sfr_rd_i,
	input logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// start sources
	input logic tmr2_ovf_i,
	input logic tmr3_ovf_i,
	input logic ext_conv_start_i,
	// system context
	input logic diff_sel_i,
	input logic conv_irq_en_i,
	// analog converter
	input logic [acwd_pkg::RES_BITS-1:0] adc_data_i,
	output logic adc_power_o,
	output logic adc_track_o,
	output logic adc_convert_o,
	// interrupt request
	output logic conv_irq_o
);

	localparam int DIV_W = (SAR_DIV > 1) ? $clog2(SAR_DIV) : 1;
	localparam int CNT_W = $clog2(CONV_SAR_CLKS + 1);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (SAR_DIV < 1)
	begin : g_bad_div
		$error("SAR_DIV must be at least 1");
	end
	if (CONV_SAR_CLKS < TRACK_SAR_CLKS)
	begin : g_bad_conv
		$error("CONV_SAR_CLKS must not be below the track length");
	end

	typedef struct packed {
		acwd_state_t state;
		logic [DIV_W-1:0] div_cnt;
		logic sar_tick;
		logic [CNT_W-1:0] cnt;
		logic enable;
		logic track_mode;
		logic done;
		logic busy;
		logic [1:0] start_mode;
		logic win;
		logic ljust;
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic [7:0] gt_lo;
		logic [7:0] gt_hi;
		logic [7:0] lt_lo;
		logic [7:0] lt_hi;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic [7:0] rdata;
		logic irq;
		logic power;
		logic track;
		logic convert;
	} acwd_regs_t;

	acwd_regs_t s_q;
	acwd_regs_t s_d;

	logic wr_ctl;
	logic sw_start;
	logic ext_rise;
	logic trigger;
	logic eoc;
	logic win_hit;
	logic [WORD_BITS-1:0] fmt_word;

	function automatic logic [7:0] ctl_byte(input acwd_regs_t r);
		ctl_byte = 8'h00;
		ctl_byte[BIT_ENABLE] = r.enable;
		ctl_byte[BIT_TRACK_MODE] = r.track_mode;
		ctl_byte[BIT_DONE] = r.done;
		ctl_byte[BIT_BUSY] = r.busy;
		ctl_byte[BIT_MODE_HI:BIT_MODE_LO] = r.start_mode;
		ctl_byte[BIT_WIN] = r.win;
		ctl_byte[BIT_LJUST] = r.ljust;
	endfunction

	function automatic logic is_wr(input logic [7:0] addr, input logic [7:0] target, input logic wr);
		is_wr = wr && (addr == target);
	endfunction

	// ----------------------------------------------------------------
	// formatter and window detector
	// ----------------------------------------------------------------
	acwd_window u_window (
		.data_i(adc_data_i),
		.left_justify_i(s_q.ljust),
		.diff_i(diff_sel_i),
		.lt_word_i({s_q.lt_hi, s_q.lt_lo}),
		.gt_word_i({s_q.gt_hi, s_q.gt_lo}),
		.word_o(fmt_word),
		.hit_o(win_hit)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.irq = 1'b0;
		s_d.sar_tick = 1'b0;

		// converter clock enable
		if (s_q.div_cnt == DIV_W'(SAR_DIV - 1))
		begin
			s_d.div_cnt = '0;
			s_d.sar_tick = 1'b1;
		end
		else
		begin
			s_d.div_cnt = s_q.div_cnt + 1'b1;
		end

		// start pin synchroniser, edge taken from the settled stages only
		s_d.ext_s1 = ext_conv_start_i;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		ext_rise = s_q.ext_s2 & ~s_q.ext_s3;

		wr_ctl = is_wr(sfr_addr_i, ADDR_CTL, sfr_wr_i);
		sw_start = wr_ctl && sfr_wdata_i[BIT_BUSY] && (s_q.start_mode == START_SW);

		case (s_q.start_mode)
			START_SW: trigger = sw_start;
			START_TMR3: trigger = tmr3_ovf_i;
			START_PIN: trigger = ext_rise;
			START_TMR2: trigger = tmr2_ovf_i;
			default: trigger = 1'b0;
		endcase

		// software writes; busy is not stored, writing 0 has no effect
		if (wr_ctl)
		begin
			s_d.enable = sfr_wdata_i[BIT_ENABLE];
			s_d.track_mode = sfr_wdata_i[BIT_TRACK_MODE];
			s_d.done = sfr_wdata_i[BIT_DONE];
			s_d.start_mode = sfr_wdata_i[BIT_MODE_HI:BIT_MODE_LO];
			s_d.win = sfr_wdata_i[BIT_WIN];
			s_d.ljust = sfr_wdata_i[BIT_LJUST];
		end
		if (is_wr(sfr_addr_i, ADDR_RES_LO, sfr_wr_i))
		begin
			s_d.res_lo = sfr_wdata_i;
		end
		if (is_wr(sfr_addr_i, ADDR_RES_HI, sfr_wr_i))
		begin
			s_d.res_hi = sfr_wdata_i;
		end
		if (is_wr(sfr_addr_i, ADDR_GT_LO, sfr_wr_i))
		begin
			s_d.gt_lo = sfr_wdata_i;
		end
		if (is_wr(sfr_addr_i, ADDR_GT_HI, sfr_wr_i))
		begin
			s_d.gt_hi = sfr_wdata_i;
		end
		if (is_wr(sfr_addr_i, ADDR_LT_LO, sfr_wr_i))
		begin
			s_d.lt_lo = sfr_wdata_i;
		end
		if (is_wr(sfr_addr_i, ADDR_LT_HI, sfr_wr_i))
		begin
			s_d.lt_hi = sfr_wdata_i;
		end

		// conversion sequencing, using control as it stood before this write
		eoc = 1'b0;
		case (s_q.state)
			ST_OFF:
			begin
				s_d.cnt = '0;
				if (s_q.enable)
				begin
					s_d.state = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				s_d.cnt = '0;
				if (trigger)
				begin
					// pin mode already tracked while the pin was low
					if (s_q.track_mode && (s_q.start_mode != START_PIN))
					begin
						s_d.state = ST_TRACK;
					end
					else
					begin
						s_d.state = ST_CONV;
					end
				end
			end
			ST_TRACK:
			begin
				if (s_q.sar_tick)
				begin
					if (s_q.cnt == CNT_W'(TRACK_SAR_CLKS - 1))
					begin
						s_d.cnt = '0;
						s_d.state = ST_CONV;
					end
					else
					begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
			end
			ST_CONV:
			begin
				if (s_q.sar_tick)
				begin
					if (s_q.cnt == CNT_W'(CONV_SAR_CLKS - 1))
					begin
						// a disable written in the previous cycle aborts: no flags, no irq
						eoc = s_q.enable;
						s_d.cnt = '0;
						s_d.state = ST_IDLE;
					end
					else
					begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
			end
			default:
			begin
				s_d.cnt = '0;
				s_d.state = ST_OFF;
			end
		endcase

		// completion overrides a same-cycle software write: set wins
		if (eoc)
		begin
			s_d.res_hi = fmt_word[WORD_BITS-1:8];
			s_d.res_lo = fmt_word[7:0];
			s_d.done = 1'b1;
			if (win_hit)
			begin
				s_d.win = 1'b1;
			end
			s_d.irq = conv_irq_en_i;
		end

		// disabling aborts any conversion in flight without completing it
		if (!s_q.enable)
		begin
			s_d.state = ST_OFF;
			s_d.cnt = '0;
		end

		s_d.busy = (s_d.state == ST_TRACK) || (s_d.state == ST_CONV);
		s_d.power = s_d.enable;
		s_d.convert = (s_d.state == ST_CONV);
		if (s_d.state == ST_TRACK)
		begin
			s_d.track = 1'b1;
		end
		else if (s_d.state == ST_IDLE)
		begin
			if (!s_q.track_mode)
			begin
				s_d.track = 1'b1;
			end
			else if (s_q.start_mode == START_PIN)
			begin
				s_d.track = ~s_q.ext_s2;
			end
			else
			begin
				s_d.track = 1'b0;
			end
		end
		else
		begin
			s_d.track = 1'b0;
		end

		// read data registered; unmapped addresses answer zero
		if (sfr_rd_i)
		begin
			case (sfr_addr_i)
				ADDR_CTL: s_d.rdata = ctl_byte(s_q);
				ADDR_RES_LO: s_d.rdata = s_q.res_lo;
				ADDR_RES_HI: s_d.rdata = s_q.res_hi;
				ADDR_GT_LO: s_d.rdata = s_q.gt_lo;
				ADDR_GT_HI: s_d.rdata = s_q.gt_hi;
				ADDR_LT_LO: s_d.rdata = s_q.lt_lo;
				ADDR_LT_HI: s_d.rdata = s_q.lt_hi;
				default: s_d.rdata = RST_RDATA;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s_q <= '{
				state: ST_OFF,
				div_cnt: '0,
				sar_tick: 1'b0,
				cnt: '0,
				enable: 1'b0,
				track_mode: 1'b0,
				done: 1'b0,
				busy: 1'b0,
				start_mode: START_SW,
				win: 1'b0,
				ljust: 1'b0,
				res_lo: RST_RES_LO,
				res_hi: RST_RES_HI,
				gt_lo: RST_GT_LO,
				gt_hi: RST_GT_HI,
				lt_lo: RST_LT_LO,
				lt_hi: RST_LT_HI,
				// stages reset high: an idle-high pin must not look like a rise
				ext_s1: 1'b1,
				ext_s2: 1'b1,
				ext_s3: 1'b1,
				rdata: RST_RDATA,
				irq: 1'b0,
				power: 1'b0,
				track: 1'b0,
				convert: 1'b0
			};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign sfr_rdata_o = s_q.rdata;
	assign adc_power_o = s_q.power;
	assign adc_track_o = s_q.track;
	assign adc_convert_o = s_q.convert;
	assign conv_irq_o = s_q.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	property p_off_quiet;
		!s_q.enable && !(wr_ctl && sfr_wdata_i[BIT_ENABLE]) |=> !adc_convert_o && !adc_power_o;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("converter active while disabled");

	property p_track_cont;
		s_q.state == ST_IDLE && s_q.enable && !s_q.track_mode && !trigger |=> adc_track_o;
	endproperty
	a_track_cont: assert property (p_track_cont) else $error("no continuous tracking");

	property p_track_len;
		s_q.state == ST_TRACK && s_d.state == ST_CONV
			|-> s_q.sar_tick && s_q.cnt == CNT_W'(TRACK_SAR_CLKS - 1);
	endproperty
	a_track_len: assert property (p_track_len) else $error("track phase length wrong");

	property p_pin_track;
		s_q.state == ST_IDLE && s_q.enable && s_q.track_mode && s_q.start_mode == START_PIN
			&& !trigger && !wr_ctl |=> adc_track_o == !$past(s_q.ext_s2);
	endproperty
	a_pin_track: assert property (p_pin_track) else $error("pin tracking mismatch");

	property p_sw_start;
		s_q.state == ST_IDLE && s_q.enable && wr_ctl && sfr_wdata_i[BIT_BUSY]
			&& sfr_wdata_i[BIT_ENABLE] && s_q.start_mode == START_SW |=> s_q.busy;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start ignored");

	property p_sw_refused;
		s_q.state == ST_IDLE && s_q.start_mode != START_SW && !trigger |=> !s_q.busy;
	endproperty
	a_sw_refused: assert property (p_sw_refused) else $error("start outside selected mode");

	property p_done_irq;
		eoc |=> s_q.done && !s_q.busy && conv_irq_o == $past(conv_irq_en_i);
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("completion not flagged");

	property p_irq_only_eoc;
		conv_irq_o |-> $past(s_q.busy) && !s_q.busy;
	endproperty
	a_irq_only_eoc: assert property (p_irq_only_eoc) else $error("interrupt without busy fall");

	property p_win_keep;
		eoc && !win_hit && !wr_ctl |=> s_q.win == $past(s_q.win);
	endproperty
	a_win_keep: assert property (p_win_keep) else $error("window flag disturbed");

	property p_ljust_pad;
		eoc && s_q.ljust |=> s_q.res_lo[3:0] == PAD_ZERO
			&& s_q.res_hi == $past(adc_data_i[RES_BITS-1:RES_BITS-8]);
	endproperty
	a_ljust_pad: assert property (p_ljust_pad) else $error("left layout wrong");

endmodule // acwd_top

// ==== testbench/acwd_core_model.sv ====
// processor core model: register bus cycles on the special function register bus
`timescale 1ns/1ps
module acwd_core_model
	import acwd_pkg::*;
(
	// clock
	input wire logic clk_sys_i,
	// register bus
	output logic [7:0] sfr_addr_o,
	output logic sfr_wr_o,
	output logic sfr_rd_o,
	output logic [7:0] sfr_wdata_o,
	input wire logic [7:0] sfr_rdata_i
);
	import acwd_pkg::*;

	initial
	begin
		sfr_addr_o = 8'h00;
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		sfr_wdata_o = 8'h00;
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// fields held until the taking edge, then scrambled so stale values never match
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		sfr_addr_o = a;
		sfr_wdata_o = d;
		sfr_wr_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		sfr_wr_o = 1'b0;
		sfr_wdata_o = ~d;
		sfr_addr_o = ~a;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_sys_i);
		#1;
		sfr_addr_o = a;
		sfr_rd_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		sfr_rd_o = 1'b0;
		sfr_addr_o = ~a;
		q = sfr_rdata_i;
	endtask

	// flags go only by software writing zero to them
	task automatic clear_flags(input logic [7:0] ctl);
		wr_reg(ADDR_CTL, ctl & 8'hdd);
	endtask
endmodule // acwd_core_model

// ==== testbench/testbench.sv ====
// self-checking testbench for the converter control and window detector
`timescale 1ns/1ps
module testbench;
	import acwd_pkg::*;
	localparam int DIV = 2;
	localparam int NCLK = 4;
	logic clk_sys_i;
	logic nrst_i;
	logic [7:0] sfr_addr_i;
	logic sfr_wr_i;
	logic sfr_rd_i;
	logic [7:0] sfr_wdata_i;
	logic [7:0] sfr_rdata_o;
	logic tmr2_ovf_i;
	logic tmr3_ovf_i;
	logic ext_conv_start_i;
	logic diff_sel_i;
	logic conv_irq_en_i;
	logic [11:0] adc_data_i;
	logic adc_power_o;
	logic adc_track_o;
	logic adc_convert_o;
	logic conv_irq_o;
	logic saw_track;
	logic [7:0] rd;
	int n_fail = 0;
	int checks = 0;
	int irq_cnt = 0;

	// short counts keep each conversion near a dozen cycles
	acwd_top #(.SAR_DIV(DIV), .CONV_SAR_CLKS(NCLK)) acwd_top_inst (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .tmr2_ovf_i(tmr2_ovf_i),
		.tmr3_ovf_i(tmr3_ovf_i), .ext_conv_start_i(ext_conv_start_i), .diff_sel_i(diff_sel_i),
		.conv_irq_en_i(conv_irq_en_i), .adc_data_i(adc_data_i), .adc_power_o(adc_power_o),
		.adc_track_o(adc_track_o), .adc_convert_o(adc_convert_o), .conv_irq_o(conv_irq_o));
	acwd_core_model core_inst (.clk_sys_i(clk_sys_i), .sfr_addr_o(sfr_addr_i),
		.sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i),
		.sfr_rdata_i(sfr_rdata_o));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge clk_sys_i)
		if (conv_irq_o === 1'b1)
			irq_cnt++;

	// ----------------------------------------------------------------
	// compare and stimulus helpers
	// ----------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		core_inst.rd_reg(a, rd);
		chk_byte(rd, exp);
	endtask

	// 1 timer 3, 3 timer 2, 2 start pin rising
	task automatic pulse(input int src);
		@(posedge clk_sys_i);
		#1;
		if (src == 1)
			tmr3_ovf_i = 1'b1;
		else if (src == 3)
			tmr2_ovf_i = 1'b1;
		else
			ext_conv_start_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		tmr3_ovf_i = 1'b0;
		tmr2_ovf_i = 1'b0;
	endtask

	// bounded waits: a start or an end that never comes counts as a mismatch
	task automatic run_conv(input int src, input logic [7:0] ctl);
		int i;
		core_inst.wr_reg(ADDR_CTL, ctl);
		saw_track = 1'b0;
		if (src == 0)
		begin
			core_inst.wr_reg(ADDR_CTL, ctl | 8'h10);
			core_inst.rd_reg(ADDR_CTL, rd);
			chk_byte(rd & 8'h10, 8'h10);
		end
		else
			pulse(src);
		for (i = 0; i < 60 && adc_convert_o !== 1'b1; i++)
		begin
			@(posedge clk_sys_i);
			#1;
			saw_track = saw_track | adc_track_o;
		end
		chk_bit(adc_convert_o, 1'b1);
		for (i = 0; i < 60 && adc_convert_o === 1'b1; i++)
		begin
			@(posedge clk_sys_i);
			#1;
		end
		chk_bit(adc_convert_o, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd_chk(ADDR_RES_LO, 8'h00);
		rd_chk(ADDR_RES_HI, 8'h00);
		rd_chk(ADDR_GT_LO, 8'hff);
		rd_chk(ADDR_GT_HI, 8'hff);
		rd_chk(ADDR_LT_LO, 8'h00);
		rd_chk(ADDR_LT_HI, 8'h00);
		rd_chk(ADDR_CTL, 8'h00);
		rd_chk(8'hbd, 8'h00);
		$display("reset values done");
	endtask

	task automatic t_sw_conv;
		int n;
		n = irq_cnt;
		adc_data_i = 12'habc;
		core_inst.wr_reg(ADDR_CTL, 8'h80);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk_bit(adc_power_o, 1'b1);
		chk_bit(adc_track_o, 1'b1);
		run_conv(0, 8'h80);
		chk_bit(adc_track_o, 1'b1);
		rd_chk(ADDR_RES_HI, 8'h0a);
		rd_chk(ADDR_RES_LO, 8'hbc);
		rd_chk(ADDR_CTL, 8'ha0);
		chk_byte(irq_cnt[7:0], n[7:0] + 8'h01);
		repeat (20) @(posedge clk_sys_i);
		rd_chk(ADDR_CTL, 8'ha0);
		core_inst.clear_flags(8'ha0);
		rd_chk(ADDR_CTL, 8'h80);
		core_inst.wr_reg(ADDR_CTL, 8'h84);
		core_inst.wr_reg(ADDR_CTL, 8'h94);
		repeat (12) @(posedge clk_sys_i);
		#1;
		chk_bit(adc_convert_o, 1'b0);
		rd_chk(ADDR_CTL, 8'h84);
		$display("software start done");
	endtask

	task automatic t_layout;
		logic [11:0] v;
		int n;
		n = irq_cnt;
		conv_irq_en_i = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			v = k[2] ? 12'h7ab : 12'h8ab;
			diff_sel_i = k[0];
			adc_data_i = v;
			run_conv(0, {7'h40, k[1]});
			rd_chk(ADDR_RES_HI, k[1] ? v[11:4] : {{4{k[0] & v[11]}}, v[11:8]});
			rd_chk(ADDR_RES_LO, k[1] ? {v[3:0], 4'h0} : v[7:0]);
		end
		chk_byte(irq_cnt[7:0], n[7:0]);
		conv_irq_en_i = 1'b1;
		$display("result layout done");
	endtask

	task automatic t_triggers;
		core_inst.wr_reg(ADDR_CTL, 8'hc4);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk_bit(adc_track_o, 1'b0);
		run_conv(1, 8'hc4);
		chk_bit(saw_track, 1'b1);
		rd_chk(ADDR_CTL, 8'he4);
		run_conv(3, 8'hcc);
		chk_bit(saw_track, 1'b1);
		rd_chk(ADDR_CTL, 8'hec);
		run_conv(0, 8'hc0);
		chk_bit(saw_track, 1'b1);
		rd_chk(ADDR_CTL, 8'he0);
		core_inst.wr_reg(ADDR_CTL, 8'hc8);
		ext_conv_start_i = 1'b0;
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk_bit(adc_track_o, 1'b1);
		run_conv(2, 8'hc8);
		chk_bit(adc_track_o, 1'b0);
		rd_chk(ADDR_CTL, 8'he8);
		$display("start sources done");
	endtask

	task automatic t_disable;
		int n;
		n = irq_cnt;
		core_inst.wr_reg(ADDR_CTL, 8'h04);
		pulse(1);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk_bit(adc_power_o, 1'b0);
		chk_bit(adc_convert_o, 1'b0);
		core_inst.wr_reg(ADDR_CTL, 8'h80);
		core_inst.wr_reg(ADDR_CTL, 8'h90);
		core_inst.wr_reg(ADDR_CTL, 8'h00);
		repeat (20) @(posedge clk_sys_i);
		rd_chk(ADDR_CTL, 8'h00);
		chk_byte(irq_cnt[7:0], n[7:0]);
		$display("disable and abort done");
	endtask

	task automatic win_case(input logic [15:0] lt, gt, input logic d, lj,
		input logic [11:0] v, input logic exp);
		core_inst.wr_reg(ADDR_LT_HI, lt[15:8]);
		core_inst.wr_reg(ADDR_LT_LO, lt[7:0]);
		core_inst.wr_reg(ADDR_GT_HI, gt[15:8]);
		core_inst.wr_reg(ADDR_GT_LO, gt[7:0]);
		diff_sel_i = d;
		adc_data_i = v;
		run_conv(0, {7'h40, lj});
		core_inst.rd_reg(ADDR_CTL, rd);
		chk_bit(rd[BIT_WIN], exp);
	endtask

	task automatic t_window;
		win_case(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h180, 1'b1);
		win_case(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h200, 1'b0);
		win_case(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h100, 1'b0);
		win_case(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h0ff, 1'b1);
		win_case(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h201, 1'b1);
		win_case(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h150, 1'b0);
		win_case(16'h0100, 16'hffff, 1'b1, 1'b0, 12'h000, 1'b1);
		win_case(16'h0100, 16'hffff, 1'b1, 1'b0, 12'hffe, 1'b0);
		win_case(16'hffff, 16'h0100, 1'b1, 1'b0, 12'hffe, 1'b1);
		win_case(16'h2000, 16'h1000, 1'b0, 1'b1, 12'h180, 1'b1);
		win_case(16'h2000, 16'h1000, 1'b0, 1'b1, 12'h200, 1'b0);
		$display("window compare done");
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		nrst_i = 1'b0;
		tmr2_ovf_i = 1'b0;
		tmr3_ovf_i = 1'b0;
		ext_conv_start_i = 1'b1;
		diff_sel_i = 1'b0;
		conv_irq_en_i = 1'b1;
		adc_data_i = 12'h000;
		repeat (10) @(posedge clk_sys_i);
		#1;
		nrst_i = 1'b1;
		t_reset();
		t_sw_conv();
		t_layout();
		t_triggers();
		t_disable();
		t_window();
		final_report();
	end

	// the tests need about 600 cycles; this allows 20000, some thirty times that
	initial
	begin
		#2000000;
		n_fail++;
		final_report();
	end
endmodule // testbench
